/* mph_cfg.svh */
// Offsets, field positions, codes and fixed values of the mode parameter handler
`ifndef MPH_CFG_SVH
`define MPH_CFG_SVH

`define MPH_OFF_CDB0    8'h00
`define MPH_OFF_CDB1    8'h04
`define MPH_OFF_CDB2    8'h08
`define MPH_OFF_CTRL    8'h0C
`define MPH_OFF_STAT    8'h10
`define MPH_OFF_DATA    8'h14
`define MPH_OFF_CNT     8'h18
`define MPH_OFF_UA      8'h1C

`define MPH_OP_SEL6     8'h15
`define MPH_OP_SEL10    8'h55
`define MPH_OP_SENSE6   8'h1A

`define MPH_BIT_PF      4
`define MPH_BIT_SP      0
`define MPH_BIT_DBD     3

`define MPH_PC_CUR      2'h0
`define MPH_PC_CHG      2'h1
`define MPH_PC_DEF      2'h2
`define MPH_PC_SAV      2'h3

`define MPH_PG_ALL      6'h3F
`define MPH_PG_CODES    {6'h00, 6'h08, 6'h02}
`define MPH_PG_PLEN     8'h02
`define MPH_DEF_PARAMS  {8'h00, 8'h00, 8'h10, 8'h04, 8'h20, 8'h80}
`define MPH_CHG_MASK    {8'hFF, 8'hFF, 8'h00, 8'h0F, 8'hFF, 8'h3F}
`define MPH_RND_MAX     8'h40
`define MPH_BLK_LEN     24'h000200

`define MPH_HDR6_LEN    16'h0004
`define MPH_HDR10_LEN   16'h0008
`define MPH_BD_LEN      16'h0008
`define MPH_ALL_LEN     16'h000C
`define MPH_ONE_LEN     16'h0004
`define MPH_SENSE6_MAX  16'h0100

`define MPH_SK_NOT_RDY  4'h2
`define MPH_SK_ILLEGAL  4'h5
`define MPH_SK_UA       4'h6
`define MPH_ASC_NOT_RDY 8'h04
`define MPH_ASC_LEN_ERR 8'h1A
`define MPH_ASC_INV_CDB 8'h24
`define MPH_ASC_INV_PRM 8'h26
`define MPH_ASC_CHANGED 8'h2A
`define MPH_ASCQ_CHG    8'h01
`define MPH_ASC_SAVE_NS 8'h39

`define MPH_RESP_OKAY   2'h0
`define MPH_RESP_SLVERR 2'h2

`endif

/* mph_pkg.sv */
// Types of the mode parameter handler
package mph_pkg;

  typedef logic [2:0][1:0][7:0] mph_pages_t;

  typedef enum logic [1:0] {
    MPH_IDLE = 2'b00,
    MPH_DOUT = 2'b01,
    MPH_DIN  = 2'b10
  } mph_state_e;

  typedef enum logic [1:0] {
    MPH_SEG_HDR  = 2'b00,
    MPH_SEG_BD   = 2'b01,
    MPH_SEG_PAGE = 2'b10,
    MPH_SEG_VEND = 2'b11
  } mph_seg_e;

  typedef struct packed {
    logic       check;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } mph_sense_s;

  typedef struct packed {
    mph_state_e      state;
    logic [9:0][7:0] cdb;
    logic [2:0]      init;
    logic [7:0]      ua;
    mph_sense_s      sense;
    logic            sel_done;
    mph_pages_t      cur;
    mph_pages_t      saved;
    mph_pages_t      shadow;
    mph_seg_e        seg;
    logic [3:0]      off;
    logic [15:0]     bdl;
    logic [15:0]     len;
    logic [15:0]     cnt;
    logic            err;
    logic            is10;
    logic            pf;
    logic            sp;
    logic            dbd;
    logic            all;
    logic [1:0]      pc;
    logic [1:0]      slot;
    logic [8:0]      total;
    logic            aw_hold;
    logic [7:0]      awaddr;
    logic            w_hold;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } mph_st_s;

endpackage

/* mph_mode_param_handler.sv */
// Mode select / mode sense command handler behind an AXI4-Lite slave
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mph_cfg.svh"

module mph_mode_param_handler
  import mph_pkg::*;
#(
  parameter int unsigned ADDR_W    = 8,
  parameter bit          SAVE_IMPL = 1'b1
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              unit_not_ready,
  output logic                   cmd_busy
);

  localparam logic [17:0] PG_CODES = `MPH_PG_CODES;
  localparam mph_pages_t  DEF_VAL  = `MPH_DEF_PARAMS;
  localparam mph_pages_t  CHG_MSK  = `MPH_CHG_MASK;

  mph_st_s    st_q;
  mph_st_s    st_d;
  mph_pages_t eff_cur;
  mph_pages_t pcv;
  logic [7:0] rb;
  logic [15:0] bdlen;
  logic [15:0] pr;
  logic [15:0] bi;
  logic [1:0]  rs;

  // Returns {hit, slot} for a page code
  function automatic logic [2:0] find_pg(input logic [5:0] code);
    find_pg = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (PG_CODES[6*i +: 6] == code) begin
        find_pg = {1'b1, 2'(i)};
      end
    end
  endfunction

  // One shared set serves every initiator, including a third party
  always_comb begin
    if (st_q.sel_done) begin
      eff_cur = st_q.cur;
    end else if (SAVE_IMPL) begin
      eff_cur = st_q.saved;
    end else begin
      eff_cur = DEF_VAL;
    end
    unique case (st_q.pc)
      `MPH_PC_CUR: pcv = eff_cur;
      `MPH_PC_CHG: pcv = CHG_MSK;
      `MPH_PC_DEF: pcv = DEF_VAL;
      `MPH_PC_SAV: pcv = st_q.saved;
    endcase
  end

  // Next sense data byte at position cnt
  always_comb begin
    rb    = 8'h00;
    bdlen = st_q.dbd ? 16'h0000 : `MPH_BD_LEN;
    pr    = 16'h0000;
    bi    = 16'h0000;
    rs    = st_q.slot;
    if (st_q.cnt < `MPH_HDR6_LEN) begin
      if (st_q.cnt[1:0] == 2'h0) begin
        rb = st_q.total[7:0] - 8'h01;
      end else if (st_q.cnt[1:0] == 2'h3) begin
        rb = bdlen[7:0];
      end
    end else if (st_q.cnt < `MPH_HDR6_LEN + bdlen) begin
      bi = st_q.cnt - `MPH_HDR6_LEN;
      if (bi[2:0] == 3'h5) begin
        rb = 8'(`MPH_BLK_LEN >> 16);
      end else if (bi[2:0] == 3'h6) begin
        rb = 8'(`MPH_BLK_LEN >> 8);
      end else if (bi[2:0] == 3'h7) begin
        rb = 8'(`MPH_BLK_LEN);
      end
    end else begin
      pr = st_q.cnt - `MPH_HDR6_LEN - bdlen;
      if (st_q.all) begin
        rs = pr[3:2];
      end
      unique case (pr[1:0])
        2'h0: rb = {SAVE_IMPL, 1'b0, PG_CODES[6*rs +: 6]};
        2'h1: rb = `MPH_PG_PLEN;
        2'h2: rb = pcv[rs][0];
        2'h3: rb = pcv[rs][1];
      endcase
    end
  end

  always_comb begin
    logic        wr_fire;
    logic        go;
    logic        bad;
    logic        fin;
    logic        trunc;
    logic [7:0]  b;
    logic [7:0]  v;
    logic [7:0]  op;
    logic [7:0]  ua_set;
    logic [7:0]  ua_clr;
    logic [7:0]  ua_me;
    logic [2:0]  f;
    logic [15:0] hl;
    logic [15:0] tot;
    int          base;
    st_d    = st_q;
    wr_fire = st_q.aw_hold & st_q.w_hold & ~st_q.bvalid;
    go      = 1'b0;
    bad     = 1'b0;
    fin     = 1'b0;
    trunc   = 1'b0;
    b       = st_q.wdata[7:0];
    v       = 8'h00;
    op      = st_q.cdb[0];
    ua_set  = 8'h00;
    ua_clr  = 8'h00;
    ua_me   = 8'h01 << st_q.init;
    f       = 3'h0;
    hl      = st_q.is10 ? `MPH_HDR10_LEN : `MPH_HDR6_LEN;
    tot     = 16'h0000;
    base    = 0;

    if (s_axi_awvalid && !st_q.aw_hold) begin
      st_d.aw_hold = 1'b1;
      st_d.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_q.w_hold) begin
      st_d.w_hold = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Register write, one per response
    if (wr_fire) begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `MPH_RESP_OKAY;
      unique case (st_q.awaddr)
        `MPH_OFF_CDB0, `MPH_OFF_CDB1, `MPH_OFF_CDB2: begin
          base = int'(st_q.awaddr);
          for (int i = 0; i < 4; i++) begin
            if (st_q.wstrb[i] && base + i < 10) begin
              st_d.cdb[base+i] = st_q.wdata[8*i +: 8];
            end
          end
        end
        `MPH_OFF_CTRL: begin
          if (st_q.wdata[0] && st_q.state == MPH_IDLE) begin
            go          = 1'b1;
            st_d.init   = st_q.wdata[10:8];
            ua_me       = 8'h01 << st_q.wdata[10:8];
          end
        end
        `MPH_OFF_DATA: begin
          fin = st_q.state == MPH_DOUT && st_q.wstrb[0];
        end
        `MPH_OFF_UA:   ua_clr = st_q.wdata[7:0];
        `MPH_OFF_STAT, `MPH_OFF_CNT: ;
        default:       st_d.bresp = `MPH_RESP_SLVERR;
      endcase
    end

    // Register read; a data read pops one sense byte
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `MPH_RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        `MPH_OFF_CDB0: st_d.rdata = {st_q.cdb[3], st_q.cdb[2], st_q.cdb[1], st_q.cdb[0]};
        `MPH_OFF_CDB1: st_d.rdata = {st_q.cdb[7], st_q.cdb[6], st_q.cdb[5], st_q.cdb[4]};
        `MPH_OFF_CDB2: st_d.rdata = {16'h0000, st_q.cdb[9], st_q.cdb[8]};
        `MPH_OFF_CTRL: st_d.rdata = {21'h000000, st_q.init, 8'h00};
        `MPH_OFF_STAT: begin
          st_d.rdata = {st_q.sense.ascq, st_q.sense.asc, 4'h0, st_q.sense.key,
                        4'h0, st_q.sense.check, 1'b0, st_q.state};
        end
        `MPH_OFF_DATA: begin
          if (st_q.state == MPH_DIN) begin
            st_d.rdata = {24'h000000, rb};
            st_d.cnt   = st_q.cnt + 16'h0001;
            if (st_q.cnt + 16'h0001 == st_q.len) begin
              st_d.state = MPH_IDLE;
            end
          end
        end
        `MPH_OFF_CNT:  st_d.rdata = {16'h0000, st_q.len - st_q.cnt};
        `MPH_OFF_UA:   st_d.rdata = {24'h000000, st_q.ua};
        default:       st_d.rresp = `MPH_RESP_SLVERR;
      endcase
    end

    // Command start
    if (go) begin
      st_d.sense = '0;
      st_d.cnt   = 16'h0000;
      // A refused command leaves no bytes to move, except a select refused for SP, which keeps its list length in len
      st_d.len   = 16'h0000;
      st_d.is10  = op == `MPH_OP_SEL10;
      st_d.pf    = st_q.cdb[1][`MPH_BIT_PF];
      st_d.sp    = st_q.cdb[1][`MPH_BIT_SP];
      st_d.dbd   = st_q.cdb[1][`MPH_BIT_DBD];
      st_d.pc    = st_q.cdb[2][7:6];
      f          = find_pg(st_q.cdb[2][5:0]);
      st_d.slot  = f[1:0];
      st_d.all   = st_q.cdb[2][5:0] == `MPH_PG_ALL;
      if ((st_q.ua & ua_me) != 8'h00) begin
        st_d.sense = '{1'b1, `MPH_SK_UA, `MPH_ASC_CHANGED, `MPH_ASCQ_CHG};
        ua_clr     = ua_clr | ua_me;
      end else if (unit_not_ready &&
                   !(op == `MPH_OP_SENSE6 && st_d.pc == `MPH_PC_DEF)) begin
        st_d.sense = '{1'b1, `MPH_SK_NOT_RDY, `MPH_ASC_NOT_RDY, 8'h00};
      end else if (op == `MPH_OP_SEL6 || op == `MPH_OP_SEL10) begin
        st_d.len = st_d.is10 ? {st_q.cdb[7], st_q.cdb[8]}
                             : {8'h00, st_q.cdb[4]};
        if (st_d.sp && !SAVE_IMPL) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_INV_CDB, 8'h00};
        end else if (st_d.len != 16'h0000) begin
          st_d.state  = MPH_DOUT;
          st_d.seg    = MPH_SEG_HDR;
          st_d.off    = 4'h0;
          st_d.bdl    = 16'h0000;
          st_d.err    = 1'b0;
          st_d.shadow = eff_cur;
        end
      end else if (op == `MPH_OP_SENSE6) begin
        tot = `MPH_HDR6_LEN + (st_d.dbd ? 16'h0000 : `MPH_BD_LEN) +
              (st_d.all ? `MPH_ALL_LEN : `MPH_ONE_LEN);
        st_d.total = tot[8:0];
        if (!st_d.all && !f[2]) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_INV_CDB, 8'h00};
        end else if (st_d.pc == `MPH_PC_SAV && !SAVE_IMPL) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_SAVE_NS, 8'h00};
        end else if (tot > `MPH_SENSE6_MAX) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_INV_CDB, 8'h00};
        end else if (st_q.cdb[4] != 8'h00) begin
          st_d.len   = {8'h00, st_q.cdb[4]} < tot ? {8'h00, st_q.cdb[4]} : tot;
          st_d.state = MPH_DIN;
        end
      end else begin
        st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_INV_CDB, 8'h00};
      end
    end

    // One parameter list byte
    if (fin) begin
      st_d.off = st_q.off + 4'h1;
      unique case (st_q.seg)
        MPH_SEG_HDR: begin
          if (!st_q.is10) begin
            bad = (st_q.off < 4'h2) && b != 8'h00;
            if (st_q.off == 4'h3) begin
              st_d.bdl = {8'h00, b};
            end
          end else begin
            bad = (st_q.off < 4'h3 || st_q.off == 4'h4 || st_q.off == 4'h5)
                  && b != 8'h00;
            if (st_q.off == 4'h6) begin
              st_d.bdl[15:8] = b;
            end
            if (st_q.off == 4'h7) begin
              st_d.bdl[7:0] = b;
            end
          end
          if ({12'h000, st_q.off} == hl - 16'h0001) begin
            st_d.off = 4'h0;
            if (st_d.bdl == `MPH_BD_LEN) begin
              st_d.seg = MPH_SEG_BD;
            end else begin
              bad      = bad | (st_d.bdl != 16'h0000);
              st_d.seg = st_q.pf && st_d.bdl == 16'h0000 ? MPH_SEG_PAGE
                                                           : MPH_SEG_VEND;
            end
          end
        end
        MPH_SEG_BD: begin
          unique case (st_q.off)
            4'h0, 4'h4: bad = b != 8'h00;
            4'h5:       bad = b != 8'(`MPH_BLK_LEN >> 16);
            4'h6:       bad = b != 8'(`MPH_BLK_LEN >> 8);
            4'h7:       bad = b != 8'(`MPH_BLK_LEN);
            default:    bad = 1'b0;
          endcase
          if (st_q.off == 4'h7) begin
            st_d.off = 4'h0;
            st_d.seg = st_q.pf ? MPH_SEG_PAGE : MPH_SEG_VEND;
          end
        end
        MPH_SEG_PAGE: begin
          if (st_q.off == 4'h0) begin
            f         = find_pg(b[5:0]);
            st_d.slot = f[1:0];
            bad       = b[7:6] != 2'h0 || !f[2];
          end else if (st_q.off == 4'h1) begin
            bad = b != `MPH_PG_PLEN;
          end else begin
            v = b;
            if (st_q.slot == 2'h0 && st_q.off == 4'h3 && b > `MPH_RND_MAX) begin
              v = `MPH_RND_MAX;
            end
            bad = ((v ^ eff_cur[st_q.slot][st_q.off[0]]) &
                   ~CHG_MSK[st_q.slot][st_q.off[0]]) != 8'h00;
            st_d.shadow[st_q.slot][st_q.off[0]] = v;
            if (st_q.off == 4'h3) begin
              st_d.off = 4'h0;
            end
          end
        end
        MPH_SEG_VEND: st_d.off = 4'h0;
      endcase
      st_d.err = st_q.err | bad;
      st_d.cnt = st_q.cnt + 16'h0001;
      if (st_q.cnt + 16'h0001 == st_q.len) begin
        st_d.state = MPH_IDLE;
        trunc = st_d.seg == MPH_SEG_HDR || st_d.seg == MPH_SEG_BD ||
                (st_d.seg == MPH_SEG_PAGE && st_d.off != 4'h0);
        if (trunc) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_LEN_ERR, 8'h00};
        end else if (st_d.err) begin
          st_d.sense = '{1'b1, `MPH_SK_ILLEGAL, `MPH_ASC_INV_PRM, 8'h00};
        end else begin
          // Only received values change; no derived side effects are applied
          st_d.cur      = st_d.shadow;
          st_d.sel_done = 1'b1;
          if (st_q.sp) begin
            st_d.saved = st_d.shadow;
          end
          if (st_d.shadow != eff_cur) begin
            ua_set = ~ua_me;
          end
        end
      end
    end

    // A new attention wins over a clear in the same cycle
    st_d.ua = (st_q.ua & ~ua_clr) | ua_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= '0;
      st_q.saved <= DEF_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = ~st_q.aw_hold;
  assign s_axi_wready  = ~st_q.w_hold;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign cmd_busy      = st_q.state != MPH_IDLE;

endmodule

`default_nettype wire

/* mph_axi_host.sv */
// Bus master model standing in for the initiator side
`timescale 1ns/1ps
`default_nettype none
module mph_axi_host (
  input  wire logic        aclk,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial begin
    {awvalid, wvalid, arvalid} = 3'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
  end
  // Released payload shows the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule
`default_nettype wire

/* mph_mode_param_handler_sva.sv */
// Handshake and command timing checks of the mode parameter handler
`timescale 1ns/1ps
`default_nettype none
`include "mph_cfg.svh"
module mph_mode_param_handler_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        cmd_busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready && !cmd_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_rise;
    $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready);
  endproperty
  a_b_rise: assert property (p_b_rise) else $error("response without write");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("response repeated");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_rerr;
    s_axi_rvalid && s_axi_rresp == `MPH_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("refused read data");
  property p_busy_on;
    $rose(cmd_busy) |-> $rose(s_axi_bvalid);
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("phase start off write");
  property p_busy_off;
    $fell(cmd_busy) && $past(aresetn) |-> s_axi_bvalid || s_axi_rvalid;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("phase end off transfer");
endmodule
bind mph_mode_param_handler mph_mode_param_handler_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .cmd_busy(cmd_busy));
`default_nettype wire

/* tb_mode_parameter_cmd_handler.sv */
// Self-checking bench of the mode parameter handler
`timescale 1ns/1ps
`default_nettype none
`include "mph_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_mode_parameter_cmd_handler;
  typedef struct packed {
    logic       nr;
    logic [7:0] op, b1, b2, b4;
    logic [3:0] k;
    logic [7:0] asc;
    logic [4:0] n, ix;
    logic [7:0] v;
  } mph_row_s;
  logic        aclk, aresetn, unr, busy, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, rdv;
  logic [3:0]  ws;
  logic [1:0]  bp, rp, rsp;
  int          checks, n_mismatch;
  int          cyc = 0;
  // Sense rows: byte ix is compared with bit 7 (savable flag) masked off
  mph_row_s rows [14] = '{
    '{1'b0, 8'h1A, 8'h00, 8'h3F, 8'hFF, 4'h0, 8'h00, 5'd24, 5'd0, 8'h17},
    '{1'b0, 8'h1A, 8'h08, 8'h3F, 8'hFF, 4'h0, 8'h00, 5'd16, 5'd3, 8'h00},
    '{1'b0, 8'h1A, 8'h08, 8'h3F, 8'hFF, 4'h0, 8'h00, 5'd16, 5'd8, 8'h08},
    '{1'b0, 8'h1A, 8'h08, 8'h3F, 8'hFF, 4'h0, 8'h00, 5'd16, 5'd4, 8'h02},
    '{1'b0, 8'h1A, 8'h08, 8'h42, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd6, 8'h3F},
    '{1'b0, 8'h1A, 8'h08, 8'h88, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd6, 8'h04},
    '{1'b0, 8'h1A, 8'h08, 8'hC2, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h20},
    '{1'b0, 8'h1A, 8'h08, 8'h05, 8'hFF, 4'h5, 8'h24, 5'd0, 5'd0, 8'h00},
    '{1'b0, 8'h1A, 8'h08, 8'h3F, 8'h04, 4'h0, 8'h00, 5'd4, 5'd0, 8'h0F},
    '{1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 4'h5, 8'h24, 5'd0, 5'd0, 8'h00},
    '{1'b0, 8'h15, 8'h10, 8'h00, 8'h00, 4'h0, 8'h00, 5'd0, 5'd0, 8'h00},
    '{1'b1, 8'h1A, 8'h08, 8'h82, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h20},
    '{1'b1, 8'h1A, 8'h08, 8'h02, 8'hFF, 4'h2, 8'h04, 5'd0, 5'd0, 8'h00},
    '{1'b0, 8'h1A, 8'h08, 8'h02, 8'h00, 4'h0, 8'h00, 5'd0, 5'd0, 8'h00}};
  mph_mode_param_handler mph_mode_param_handler_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rp), .unit_not_ready(unr),
    .cmd_busy(busy));
  mph_axi_host mph_axi_host_i (
    .aclk(aclk), .awvalid(awv), .awready(awr), .awaddr(awa), .wvalid(wv), .wready(wrd),
    .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br), .bresp(bp), .arvalid(arv),
    .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr), .rdata(rd), .rresp(rp));
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    mph_axi_host_i.wr(a, d, rsp);
  endtask
  task automatic r(input logic [7:0] a);
    mph_axi_host_i.rd(a, rdv, rsp);
  endtask
  task automatic cmd(input logic [2:0] id, input logic [79:0] c);
    w(`MPH_OFF_CDB0, c[31:0]);
    w(`MPH_OFF_CDB1, c[63:32]);
    w(`MPH_OFF_CDB2, {16'h0000, c[79:64]});
    w(`MPH_OFF_CTRL, {21'h0, id, 8'h01});
  endtask
  task automatic st(input logic [3:0] k, input logic [7:0] asc);
    r(`MPH_OFF_STAT);
    `CHK("state", 2'h0, rdv[1:0])
    `CHK("check", k != 4'h0, rdv[3])
    `CHK("key", k, rdv[11:8])
    `CHK("asc", asc, rdv[23:16])
  endtask
  task automatic run(input logic [2:0] id, input mph_row_s t);
    unr <= t.nr;
    cmd(id, {32'h0, 8'h00, t.b4, 8'h00, t.b2, t.b1, t.op});
    r(`MPH_OFF_CNT);
    `CHK("count", 16'(t.n), rdv[15:0])
    for (int j = 0; j < t.n; j++) begin
      r(`MPH_OFF_DATA);
      if (j == t.ix) `CHK("byte", t.v, rdv[7:0] & 8'h7F)
    end
    st(t.k, t.asc);
  endtask
  task automatic sel(input bit lng, input logic [7:0] b1, input logic [7:0] q[$],
                     input logic [3:0] k, input logic [7:0] asc);
    if (lng) cmd(3'd0, {8'h00, 8'(q.size()), 8'h00, 40'h0, b1, `MPH_OP_SEL10});
    else cmd(3'd0, {32'h0, 8'h00, 8'(q.size()), 16'h0, b1, `MPH_OP_SEL6});
    foreach (q[i]) w(`MPH_OFF_DATA, {24'h0, q[i]});
    st(k, asc);
  endtask
  task automatic ua(input logic [7:0] e);
    r(`MPH_OFF_UA);
    `CHK("attention mask", e, rdv[7:0])
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    aresetn = 1'b0;
    unr = 1'b0;
    checks = 0;
    n_mismatch = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(4'h0, 8'h00);
    ua(8'h00);
    r(8'h20);
    `CHK("read resp", `MPH_RESP_SLVERR, rsp)
    w(8'h20, 32'h0);
    `CHK("write resp", `MPH_RESP_SLVERR, rsp)
    foreach (rows[i]) run(3'd0, rows[i]);
    // Saved select with a rounded value, then current and saved readback
    sel(1'b0, 8'h11, {8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'hBF, 8'h50}, 4'h0, 8'h00);
    run(3'd0, '{1'b0, 8'h1A, 8'h08, 8'h02, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h40});
    run(3'd0, '{1'b0, 8'h1A, 8'h08, 8'hC2, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h40});
    ua(8'hFE);
    run(3'd1, '{1'b0, 8'h1A, 8'h08, 8'h02, 8'hFF, 4'h6, 8'h2A, 5'd0, 5'd0, 8'h00});
    ua(8'hFC);
    w(`MPH_OFF_UA, 32'h000000FF);
    ua(8'h00);
    // Rejected lists leave the committed values alone
    sel(1'b0, 8'h10, {8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h02, 8'h04, 8'h11}, 4'h5, 8'h26);
    sel(1'b0, 8'h10, {8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h3F, 8'h20}, 4'h5, 8'h26);
    sel(1'b0, 8'h10, {8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02}, 4'h5, 8'h1A);
    run(3'd0, '{1'b0, 8'h1A, 8'h08, 8'h02, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h40});
    sel(1'b1, 8'h10, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                      8'h02, 8'h02, 8'hBF, 8'h20}, 4'h0, 8'h00);
    run(3'd0, '{1'b0, 8'h1A, 8'h08, 8'h02, 8'hFF, 4'h0, 8'h00, 5'd8, 5'd7, 8'h20});
    give_verdict();
  end
endmodule
`default_nettype wire
